// ---- hdl/sar_adc_sequencer.sv ----
// Notes on behaviour
// RULE_01: Every conversion yields an eight-bit result.
// RULE_02: A conversion lasts exactly thirteen bit periods; divisor sets only period length.
// RULE_03: Bit period comes only from the internal oscillator divided by four.
// RULE_04: Hence each conversion finishes thirteen instruction cycles after its start.
// RULE_05: Any reset sets both analog pin-select bits.
// RULE_06: A pin selected as analog has its digital output driver disabled.
// RULE_07: Pin-select bits act on pins whatever the power-on bit holds.
// RULE_08: Software leaves pin and channel select alone during a conversion.
// RULE_09: Reference channel is always selectable; pin channels need their pin analog.
// RULE_10: Writing go/done one starts a conversion; it reads one while busy.
// RULE_11: Hardware clears go/done when the conversion completes.
// RULE_12: Clearing go/done mid-conversion stops at once, keeping the partial result.
// RULE_13: With power-on clear, a go/done write of one is ignored.
// RULE_14: Sleep clears go/done and power-on, stops, and forces channel to 11.
// RULE_15: On wake the control register holds pins 11, channel 11, go and power clear.
// RULE_16: The previous result stays readable during the next sampling period.
// RULE_17: After sampling the result clears and a marker one enters at the top.
// RULE_18: Each decided bit moves the marker right; nine shifts end the conversion.
// RULE_19: After abort the marker position shows how many bits were decided.
// RULE_20: Sleep leaves partial data only if at least one bit was decided.
// RULE_21: Software should clear power-on when no conversions are needed.
// RULE_22: Channel 00 is pin 0, 01 is pin 1, 1x is the internal reference.
// RULE_23: Control bits: pins 7:6, channel 3:2, go/done 1, power 0, bits 5:4 zero.
// RULE_24: Software writes to the result register have no effect.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // AXI4-Lite write address and data.
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels.
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Power manager events, same clock domain.
    input wire logic sleep_enter_i,
    input wire logic wake_i,
    // Analog front end.
    input wire logic comparator_i,
    output sar_adc_pkg::analog_ctrl_t analog_ctrl_o,
    output logic [1:0] pin_digital_out_disable_o
);

    // Control and result storage.
    sar_adc_pkg::converter_control_reg_t ctrl;
    logic [7:0] conversion_result;

    // Sequencer state.
    sar_adc_pkg::seq_state_t state;
    logic [1:0] prescale;
    logic [3:0] period_count;
    logic [3:0] marker_pos;
    logic bit_tick;

    // Registered comparator decision.
    logic cmp_level;

    // Bus capture state.
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic write_fire;
    logic write_ctrl;
    logic write_hits;
    sar_adc_pkg::converter_control_reg_t next_ctrl_written;
    logic [7:0] ar_offset;
    logic abort_write;

    // The front end latches its comparator on this same clock, so one flop is enough.
    // A three-stage synchroniser would push each decision past the four-clock bit period.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cmp_level <= 1'b0;
        end else begin
            cmp_level <= comparator_i;
        end
    end

    // Write address and data are taken independently, in either order, one at a time.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i[7:0];
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (write_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
            // Ready rises again only once the response has been accepted.
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // A write commits in the cycle after both halves are held.
    assign write_fire = aw_held && w_held && !s_axi_bvalid_o;
    assign write_hits = (aw_addr == sar_adc_pkg::CTRL_OFFSET)
        || (aw_addr == sar_adc_pkg::RESULT_OFFSET);
    assign write_ctrl = write_fire && (aw_addr == sar_adc_pkg::CTRL_OFFSET) && w_strb[0];
    assign next_ctrl_written = sar_adc_pkg::converter_control_reg_t'(w_data[7:0]);
    // Of all writes, only a control write without a powered start stops a running conversion.
    assign abort_write = write_ctrl
        && !(next_ctrl_written.go_done && next_ctrl_written.converter_power_on);

    // Write response; the result register accepts the write but keeps its value.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= sar_adc_pkg::RESP_OKAY;
        end else if (write_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= write_hits ? sar_adc_pkg::RESP_OKAY : sar_adc_pkg::RESP_SLVERR; // RULE_24
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Read channel: one read at a time, data answered the cycle after the address.
    assign ar_offset = s_axi_araddr_i[7:0];
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= sar_adc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= sar_adc_pkg::RESP_OKAY;
            if (ar_offset == sar_adc_pkg::CTRL_OFFSET) begin
                s_axi_rdata_o <= {24'h00_0000, ctrl.analog_pin_select, 2'h0, // RULE_23
                    ctrl.input_channel_select, ctrl.go_done, ctrl.converter_power_on};
            end else if (ar_offset == sar_adc_pkg::RESULT_OFFSET) begin
                s_axi_rdata_o <= {24'h00_0000, conversion_result};
            end else begin
                s_axi_rdata_o <= 32'h0000_0000;
                s_axi_rresp_o <= sar_adc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // Bit period strobe: system clock divided by four, no other source exists.
    // The divider runs only while converting so every conversion starts aligned.
    assign bit_tick = (prescale == 2'(sar_adc_pkg::CLOCKS_PER_BIT_PERIOD - 1)); // RULE_03
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prescale <= 2'h0;
        end else if (state == sar_adc_pkg::SEQ_IDLE) begin
            prescale <= 2'h0;
        end else begin
            prescale <= prescale + 2'h1;
        end
    end

    // Control register. Sleep outranks wake, wake outranks software, and a
    // software start outranks the hardware completion clear in the same cycle.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl.analog_pin_select <= sar_adc_pkg::PIN_SELECT_RESET; // RULE_05
            ctrl.unused <= 2'h0;
            ctrl.input_channel_select <= sar_adc_pkg::CHANNEL_RESET;
            ctrl.go_done <= 1'b0;
            ctrl.converter_power_on <= 1'b0;
        end else if (sleep_enter_i) begin
            ctrl.input_channel_select <= sar_adc_pkg::CHANNEL_RESET; // RULE_14
            ctrl.go_done <= 1'b0;
            ctrl.converter_power_on <= 1'b0;
        end else if (wake_i) begin
            ctrl.analog_pin_select <= sar_adc_pkg::PIN_SELECT_RESET; // RULE_15
            ctrl.input_channel_select <= sar_adc_pkg::CHANNEL_RESET;
            ctrl.go_done <= 1'b0;
            ctrl.converter_power_on <= 1'b0;
        end else if (write_ctrl) begin
            ctrl.analog_pin_select <= next_ctrl_written.analog_pin_select;
            ctrl.input_channel_select <= next_ctrl_written.input_channel_select;
            ctrl.converter_power_on <= next_ctrl_written.converter_power_on;
            // Go needs power on in the same write; otherwise it stays clear.
            ctrl.go_done <= next_ctrl_written.go_done
                && next_ctrl_written.converter_power_on; // RULE_10 RULE_13
        end else if (state == sar_adc_pkg::SEQ_SETTLE && bit_tick
            && period_count == 4'(sar_adc_pkg::BIT_PERIODS_PER_CONVERSION - 1)) begin
            ctrl.go_done <= 1'b0; // RULE_11
        end
    end

    // Sequencer. A write that clears go, or a sleep, drops straight to idle and
    // leaves the result register exactly as it stood.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= sar_adc_pkg::SEQ_IDLE;
            period_count <= 4'h0;
        end else if (sleep_enter_i || wake_i) begin
            state <= sar_adc_pkg::SEQ_IDLE; // RULE_14
            period_count <= 4'h0;
        end else if (write_ctrl && !(next_ctrl_written.go_done
            && next_ctrl_written.converter_power_on)) begin
            state <= sar_adc_pkg::SEQ_IDLE; // RULE_12
            period_count <= 4'h0;
        end else if (write_ctrl && state == sar_adc_pkg::SEQ_IDLE) begin
            state <= sar_adc_pkg::SEQ_SAMPLE; // RULE_10
            period_count <= 4'h0;
        end else if (bit_tick) begin
            period_count <= period_count + 4'h1; // RULE_02
            case (state)
                sar_adc_pkg::SEQ_SAMPLE: begin
                    if (period_count == 4'(sar_adc_pkg::SAMPLE_BIT_PERIODS - 1)) begin
                        state <= sar_adc_pkg::SEQ_DECIDE;
                    end
                end
                sar_adc_pkg::SEQ_DECIDE: begin
                    if (marker_pos == 4'h0) begin
                        state <= sar_adc_pkg::SEQ_SETTLE;
                    end
                end
                sar_adc_pkg::SEQ_SETTLE: begin
                    if (period_count
                        == 4'(sar_adc_pkg::BIT_PERIODS_PER_CONVERSION - 1)) begin
                        state <= sar_adc_pkg::SEQ_IDLE; // RULE_04
                        period_count <= 4'h0;
                    end
                end
                default: begin
                    state <= sar_adc_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // Result register with a travelling marker. The old result survives the
    // sampling periods; at their end it clears and the marker enters at bit 7.
    // Each later period stores the comparator decision where the marker sat and
    // moves the marker down one place; the ninth shift pushes it out.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            conversion_result <= 8'h00;
            marker_pos <= 4'h0;
        end else if (bit_tick && !sleep_enter_i && !wake_i && !abort_write) begin
            if (state == sar_adc_pkg::SEQ_SAMPLE
                && period_count == 4'(sar_adc_pkg::SAMPLE_BIT_PERIODS - 1)) begin
                conversion_result <= 8'h80; // RULE_16 RULE_17
                marker_pos <= 4'(sar_adc_pkg::RESULT_WIDTH);
            end else if (state == sar_adc_pkg::SEQ_DECIDE && marker_pos != 4'h0) begin
                conversion_result[3'(marker_pos - 4'h1)] <= cmp_level; // RULE_18 RULE_01
                if (marker_pos > 4'h1) begin
                    conversion_result[3'(marker_pos - 4'h2)] <= 1'b1; // RULE_19
                end
                marker_pos <= marker_pos - 4'h1;
            end
        end
    end

    // Analog drive. The trial code is the result register itself: decided bits
    // above the marker, the marker as the bit under test, zeros below. On abort
    // or sleep the register is simply left, so partial data needs a decided bit.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            analog_ctrl_o <= '0;
        end else begin
            analog_ctrl_o.powered <= ctrl.converter_power_on && !sleep_enter_i; // RULE_14
            analog_ctrl_o.sampling <= (state == sar_adc_pkg::SEQ_SAMPLE);
            analog_ctrl_o.channel <= ctrl.input_channel_select; // RULE_22 RULE_09
            analog_ctrl_o.trial_code <= conversion_result; // RULE_20
        end
    end

    // Pin drivers follow the pin-select bits regardless of converter power.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_digital_out_disable_o <= sar_adc_pkg::PIN_SELECT_RESET;
        end else begin
            pin_digital_out_disable_o <= ctrl.analog_pin_select; // RULE_06 RULE_07
        end
    end

endmodule // sar_adc_sequencer

`default_nettype wire

// ---- inc/sar_adc_pkg.sv ----
package sar_adc_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] RESULT_OFFSET = 8'h04;

    // Control register field positions.
    localparam int POWER_ON_BIT = 0;
    localparam int GO_DONE_BIT = 1;
    localparam int CHANNEL_LSB = 2;
    localparam int PIN_SELECT_LSB = 6;

    // Reset and wake values of the control fields.
    localparam logic [1:0] PIN_SELECT_RESET = 2'h3;
    localparam logic [1:0] CHANNEL_RESET = 2'h3;

    // Channel decode values; any code with the top bit set picks the reference.
    localparam logic [1:0] CHANNEL_PIN0 = 2'h0;
    localparam logic [1:0] CHANNEL_PIN1 = 2'h1;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Conversion timing: one bit period is the system clock divided by four.
    localparam int CLOCK_PERIOD_NS = 5;
    localparam int CLOCKS_PER_BIT_PERIOD = 4;
    localparam int BIT_PERIOD_NS = CLOCK_PERIOD_NS * CLOCKS_PER_BIT_PERIOD;
    localparam int BIT_PERIODS_PER_CONVERSION = 13;
    localparam int SAMPLE_BIT_PERIODS = 3;
    localparam int RESULT_WIDTH = 8;
    localparam int MARKER_SHIFTS = RESULT_WIDTH + 1;
    localparam int CONVERSION_CLOCKS = CLOCKS_PER_BIT_PERIOD * BIT_PERIODS_PER_CONVERSION;

    // Control register layout, carried as one unit.
    typedef struct packed {
        logic [1:0] analog_pin_select;
        logic [1:0] unused;
        logic [1:0] input_channel_select;
        logic go_done;
        logic converter_power_on;
    } converter_control_reg_t;

    // Analog-side controls that travel together to the front end.
    typedef struct packed {
        logic powered;
        logic sampling;
        logic [1:0] channel;
        logic [7:0] trial_code;
    } analog_ctrl_t;

    // Sequencer phases.
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SAMPLE,
        SEQ_DECIDE,
        SEQ_SETTLE
    } seq_state_t;

endpackage

// ---- tb/analog_front_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module analog_front_model (
    // Clock.
    input wire logic clk_i,
    // Levels seen on pin 0, pin 1 and the fixed reference.
    input wire logic [7:0] pin0_level_i,
    input wire logic [7:0] pin1_level_i,
    input wire logic [7:0] ref_level_i,
    // Converter side.
    input wire sar_adc_pkg::analog_ctrl_t ctrl_i,
    output logic comparator_o
);
    logic [7:0] held = 8'h00;

    initial comparator_o = 1'b0;

    // The hold follows the channel while sampling; the comparator settles one clock after a
    // trial code change, well inside the four-clock bit period.
    always @(posedge clk_i) begin
        if (!ctrl_i.powered) begin
            comparator_o <= ~comparator_o; // An unpowered comparator gives junk, not a tidy zero.
        end else if (ctrl_i.sampling) begin
            held <= ctrl_i.channel[1] ? ref_level_i :
                (ctrl_i.channel[0] ? pin1_level_i : pin0_level_i);
        end else begin
            comparator_o <= (held >= ctrl_i.trial_code);
        end
    end
endmodule // analog_front_model

`default_nettype wire

// ---- tb/sar_adc_sequencer_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer_chk (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // Read data channel.
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    // Power events and analog side.
    input wire logic sleep_enter_i,
    input wire logic wake_i,
    input wire sar_adc_pkg::analog_ctrl_t analog_ctrl_o,
    input wire logic [1:0] pin_digital_out_disable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // Lowest set bit of a trial code is the bit now being decided.
    function automatic logic [7:0] low_bit(input logic [7:0] x);
        return x & (~x + 8'h01);
    endfunction

    // Register reads never show bits beyond the eight-bit registers.
    upper_zero_a: assert property (
        s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0) else $error("read upper bits set");
    wake_pins_a: assert property (wake_i && !sleep_enter_i |-> ##2
        pin_digital_out_disable_o == 2'b11 && !analog_ctrl_o.powered) else $error("wake state");
    sleep_pins_a: assert property (
        sleep_enter_i |=> $stable(pin_digital_out_disable_o)) else $error("sleep moved pins");
    sleep_off_a: assert property (sleep_enter_i |=>
        !analog_ctrl_o.powered ##1 !analog_ctrl_o.sampling) else $error("sleep left power on");
    power_first_a: assert property (
        $rose(analog_ctrl_o.sampling) |-> analog_ctrl_o.powered) else $error("sample unpowered");
    // A full sampling period ends with the marker alone at the top.
    first_trial_a: assert property ($fell(analog_ctrl_o.sampling) &&
        $past(analog_ctrl_o.sampling, 11) && analog_ctrl_o.powered
        |-> ##[0:2] analog_ctrl_o.trial_code == 8'h80) else $error("first trial wrong");
    // Trial codes change no faster than one bit period of four clocks.
    bit_period_a: assert property ($changed(analog_ctrl_o.trial_code) &&
        analog_ctrl_o.trial_code != 8'h00 |=> (analog_ctrl_o.trial_code == 8'h00
        || $stable(analog_ctrl_o.trial_code))[*3]) else $error("bit period short");
    // Each decision moves the marker exactly one place down.
    marker_step_a: assert property ($changed(analog_ctrl_o.trial_code) &&
        analog_ctrl_o.trial_code != 8'h00 && analog_ctrl_o.trial_code != 8'h80
        && $past(analog_ctrl_o.trial_code) != 8'h00 && !$past(analog_ctrl_o.trial_code[0])
        |-> low_bit(analog_ctrl_o.trial_code) == (low_bit($past(analog_ctrl_o.trial_code)) >> 1))
        else $error("marker step wrong");
endmodule // sar_adc_sequencer_chk

bind sar_adc_sequencer sar_adc_sequencer_chk sar_adc_sequencer_chk_i (
    .clk_i(clk_i), .reset_i(reset_i), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .sleep_enter_i(sleep_enter_i), .wake_i(wake_i),
    .analog_ctrl_o(analog_ctrl_o), .pin_digital_out_disable_o(pin_digital_out_disable_o));

`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd, saved;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic sleep_enter = 1'b0, wake = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, comparator;
    logic [1:0] bresp, rresp, rsp, pins;
    logic [7:0] lvl [3] = '{8'ha5, 8'h3c, 8'h5a};
    sar_adc_pkg::analog_ctrl_t actrl;
    int fails = 0, compares = 0, cyc = 0, t_b = 0, t_ar = 0;

    // Clock and an edge counter used to time conversions.
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;

    sar_adc_sequencer sar_adc_sequencer_i (
        .clk_i(clk_i), .reset_i(reset_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sleep_enter_i(sleep_enter),
        .wake_i(wake), .comparator_i(comparator), .analog_ctrl_o(actrl),
        .pin_digital_out_disable_o(pins));

    analog_front_model analog_front_model_i (
        .clk_i(clk_i), .pin0_level_i(lvl[0]), .pin1_level_i(lvl[1]), .ref_level_i(lvl[2]),
        .ctrl_i(actrl), .comparator_o(comparator));

    // Counts every comparison and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Write: address and data go out together and each drops once taken. The closing edge
    // keeps a following call from assigning the handshake twice in one time step.
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            t_b = cyc;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        rsp = bresp;
        @(posedge clk_i);
    endtask

    // Read: t_ar notes the edge at which the address was taken.
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arvalid && arready) t_ar = cyc;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rsp = rresp;
        d = rdata;
        @(posedge clk_i);
    endtask

    // A cut-short result: a marker is present, bits above it match, bits below it are clear.
    task automatic check_partial(input logic [7:0] r, input logic [7:0] lv);
        logic [7:0] m;
        m = r ^ (r - 8'h01);
        check(r != 8'h00, 1'b1);
        check(r & ~m, lv & ~m);
        check(r & (m >> 1), 8'h00);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence of register-level tests.
    initial begin
        logic [31:0] cv;
        int t0;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        bus_read(sar_adc_pkg::CTRL_OFFSET, rd);
        check(rd, 32'hcc);
        check(pins, 2'b11);
        bus_read(8'h08, rd);
        check(rd, 32'h0);
        check(rsp, sar_adc_pkg::RESP_SLVERR);
        bus_write(8'h08, 32'h0);
        check(rsp, sar_adc_pkg::RESP_SLVERR);
        $display("test reset_and_map done");
        // Pin select works with the converter off; go cannot be set without power.
        bus_write(sar_adc_pkg::CTRL_OFFSET, 32'h70);
        check(pins, 2'b01);
        bus_write(sar_adc_pkg::CTRL_OFFSET, 32'h4e);
        bus_read(sar_adc_pkg::CTRL_OFFSET, rd);
        check(rd, 32'h4c);
        $display("test pins_and_power done");
        // Every channel code; reference codes run with both pins digital.
        for (int ch = 0; ch < 4; ch++) begin
            cv = {24'h0, ch[1] ? 2'b00 : 2'b11, 2'b00, ch[1:0], 2'b11};
            bus_read(sar_adc_pkg::RESULT_OFFSET, saved);
            bus_write(sar_adc_pkg::CTRL_OFFSET, cv);
            t0 = t_b;
            bus_read(sar_adc_pkg::CTRL_OFFSET, rd);
            check(rd, cv);
            bus_read(sar_adc_pkg::RESULT_OFFSET, rd);
            check(rd, saved);
            bus_write(sar_adc_pkg::CTRL_OFFSET, cv);
            do bus_read(sar_adc_pkg::CTRL_OFFSET, rd); while (rd[1] === 1'b1);
            check(rd, cv & 32'hfd);
            check((t_ar - t0) inside {[50:57]}, 1'b1);
            bus_read(sar_adc_pkg::RESULT_OFFSET, rd);
            check(rd, lvl[ch[1] ? 2 : ch]);
        end
        bus_write(sar_adc_pkg::RESULT_OFFSET, 32'hff);
        check(rsp, sar_adc_pkg::RESP_OKAY);
        bus_read(sar_adc_pkg::RESULT_OFFSET, rd);
        check(rd, lvl[2]);
        $display("test conversions done");
        // Abort in the middle; the partial result must then hold still.
        bus_write(sar_adc_pkg::CTRL_OFFSET, 32'hc3);
        repeat (25) @(posedge clk_i);
        bus_write(sar_adc_pkg::CTRL_OFFSET, 32'hc1);
        bus_read(sar_adc_pkg::RESULT_OFFSET, saved);
        check_partial(saved[7:0], lvl[0]);
        repeat (20) @(posedge clk_i);
        bus_read(sar_adc_pkg::RESULT_OFFSET, rd);
        check(rd, saved);
        bus_read(sar_adc_pkg::CTRL_OFFSET, rd);
        check(rd, 32'hc1);
        $display("test abort done");
        // Sleep in the middle of a conversion, then wake.
        bus_write(sar_adc_pkg::CTRL_OFFSET, 32'h43);
        repeat (25) @(posedge clk_i);
        sleep_enter <= 1'b1;
        @(posedge clk_i);
        sleep_enter <= 1'b0;
        bus_read(sar_adc_pkg::CTRL_OFFSET, rd);
        check(rd, 32'h4c);
        check(pins, 2'b01);
        check(actrl.powered, 1'b0);
        bus_read(sar_adc_pkg::RESULT_OFFSET, rd);
        check_partial(rd[7:0], lvl[0]);
        wake <= 1'b1;
        @(posedge clk_i);
        wake <= 1'b0;
        bus_read(sar_adc_pkg::CTRL_OFFSET, rd);
        check(rd, 32'hcc);
        check(pins, 2'b11);
        $display("test sleep_and_wake done");
        end_of_test();
    end

    // Watchdog: the tests need well under 3000 cycles.
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        $display("ERROR at %0t ns: watchdog ran out", $time);
        end_of_test();
    end
endmodule // testbench

`default_nettype wire
